// File: rtl/adcctl_top.sv
// converter control: registers, trigger logic, result presentation
// assumes wishbone classic slave, analog core answers via result only, the end is set by the cycle count
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module adcctl_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic GLOBAL_IRQ_EN_IN,
  input wire logic VECTOR_TAKEN_IN,
  input wire logic [7:1] TRIG_FLAGS_IN,
  input wire logic [adcctl_pkg::ADCCTL_RES_W-1:0] CONV_RESULT_IN,
  input wire logic [7:0] PORT_PIN_IN,
  output logic [7:0] PORT_PIN_OUT,
  output logic [7:0] PIN_BUFFER_OFF_OUT,
  output logic COMPARATOR_MUX_BORROW_OUT,
  output logic [3:0] CHANNEL_SELECT_OUT,
  output logic [1:0] REFERENCE_SELECT_OUT,
  output logic CONVERTER_ON_OUT,
  output logic SAMPLE_OUT,
  output logic COMPLETE_IRQ_OUT
);
  import adcctl_pkg::*;
  // ============================================================
  // registers
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] mux_r;
  logic [7:0] pin_dis_r;
  logic [9:0] result_r;
  logic locked_r;
  logic trig_prev_r;
  logic first_r;
  logic [4:0] cyc_r;
  adcctl_state_t state_r;
  adcctl_state_t state_nxt;
  logic adc_tick;

  // ============================================================
  // bus decode
  wire access = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  wire wr = access && WB_WE_IN && WB_SEL_IN[0];
  wire rd = access && !WB_WE_IN;
  wire wr_a = wr && (WB_ADR_IN == ADCCTL_OFS_CTRL_A);
  wire wr_b = wr && (WB_ADR_IN == ADCCTL_OFS_CTRL_B);
  wire wr_mux = wr && (WB_ADR_IN == ADCCTL_OFS_MUX);
  wire wr_dis = wr && (WB_ADR_IN == ADCCTL_OFS_PIN_DIS);
  wire rd_lo = rd && (WB_ADR_IN == ADCCTL_OFS_RES_LO);
  wire rd_hi = rd && (WB_ADR_IN == ADCCTL_OFS_RES_HI);
  wire [7:0] wdat = WB_DAT_IN[7:0];

  wire en = ctrl_a_r[ADCCTL_BIT_EN];
  wire auto_en = ctrl_a_r[ADCCTL_BIT_AUTO];
  wire done_flag = ctrl_a_r[ADCCTL_BIT_DONE];
  wire [2:0] trig_sel = ctrl_b_r[2:0];
  wire align_left = mux_r[ADCCTL_BIT_ALIGN];

  // ============================================================
  // result presentation
  wire [7:0] res_lo = align_left ? {result_r[1:0], 6'h00} : result_r[7:0];
  wire [7:0] res_hi = align_left ? result_r[9:2] : {6'h00, result_r[9:8]};

  // ============================================================
  // trigger selection: free running reuses the done flag
  wire [7:0] trig_vec = {TRIG_FLAGS_IN, done_flag};
  wire trig_sig = trig_vec[trig_sel];
  // free running never edges on selection change, only on flag rise
  wire trig_edge = auto_en && trig_sig && !trig_prev_r;
  wire free_sel = (trig_sel == ADCCTL_TRIG_FREE);
  wire sel_change = wr_b && (wdat[2:0] != trig_sel);
  logic sel_change_d;
  wire auto_start = trig_edge && !(free_sel && sel_change_d);
  wire sw_start = wr_a && wdat[ADCCTL_BIT_START] && wdat[ADCCTL_BIT_EN];
  wire start_req = en && (sw_start || auto_start || ctrl_a_r[ADCCTL_BIT_START]);
  wire conv_end = (state_r == ADCCTL_CONV) && adc_tick && (cyc_r == 5'h01);
  // a low read in the completion cycle locks too, so the pair is never torn
  wire set_done = conv_end && !locked_r && !rd_lo;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCCTL_IDLE: begin
        if (start_req) begin
          state_nxt = ADCCTL_CONV;
        end
      end
      ADCCTL_CONV: begin
        if (!en) begin
          state_nxt = ADCCTL_IDLE;
        end else if (conv_end) begin
          state_nxt = ADCCTL_DONE;
        end
      end
      ADCCTL_DONE: begin
        state_nxt = ADCCTL_IDLE;
      end
      default: begin
        state_nxt = ADCCTL_IDLE;
      end
    endcase
  end

  adcctl_prescaler u_presc (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .run_in(en),
    .sel_in(ctrl_a_r[2:0]),
    .tick_out(adc_tick)
  );

  // ============================================================
  // control register a with done flag: set wins over clear
  logic [7:0] ctrl_a_nxt;
  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    if (wr_a) begin
      ctrl_a_nxt = {wdat[7:5], ctrl_a_r[4], wdat[3:0]};
      ctrl_a_nxt[ADCCTL_BIT_START] = ctrl_a_r[ADCCTL_BIT_START] | wdat[ADCCTL_BIT_START];
      if (wdat[ADCCTL_BIT_DONE]) begin
        ctrl_a_nxt[ADCCTL_BIT_DONE] = 1'b0;
      end
    end
    if (VECTOR_TAKEN_IN) begin
      ctrl_a_nxt[ADCCTL_BIT_DONE] = 1'b0;
    end
    if (state_r == ADCCTL_IDLE && start_req) begin
      ctrl_a_nxt[ADCCTL_BIT_START] = 1'b1;
    end
    if (conv_end || !ctrl_a_nxt[ADCCTL_BIT_EN]) begin
      ctrl_a_nxt[ADCCTL_BIT_START] = 1'b0;
    end
    if (set_done) begin
      ctrl_a_nxt[ADCCTL_BIT_DONE] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= ADCCTL_IDLE;
      ctrl_a_r <= ADCCTL_RESET_VAL;
      ctrl_b_r <= ADCCTL_RESET_VAL;
      mux_r <= ADCCTL_RESET_VAL;
      pin_dis_r <= ADCCTL_RESET_VAL;
      first_r <= 1'b1;
      cyc_r <= 5'h00;
      trig_prev_r <= 1'b0;
      sel_change_d <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      trig_prev_r <= trig_sig;
      sel_change_d <= sel_change;
      if (wr_b) begin
        ctrl_b_r <= {1'b0, wdat[6], 3'h0, wdat[2:0]};
      end
      if (wr_mux) begin
        mux_r <= {wdat[7:5], 1'b0, wdat[3:0]};
      end
      if (wr_dis) begin
        pin_dis_r <= wdat;
      end
      // first conversion after enable is the long one
      if (!en) begin
        first_r <= 1'b1;
      end else if (conv_end) begin
        first_r <= 1'b0;
      end
      if (state_r == ADCCTL_IDLE && start_req) begin
        cyc_r <= first_r ? ADCCTL_FIRST_CYCLES : ADCCTL_CONV_CYCLES;
      end else if (state_r == ADCCTL_CONV && adc_tick) begin
        cyc_r <= cyc_r - 5'h01;
      end
    end
  end

  // ============================================================
  // result lock and capture
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result_r <= 10'h000;
      locked_r <= 1'b0;
    end else begin
      if (set_done) begin
        result_r <= CONV_RESULT_IN;
      end
      if (rd_lo) begin
        locked_r <= 1'b1;
      end else if (rd_hi) begin
        locked_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // bus answer: one wait state, unmapped reads zero
  wire [7:0] rd_mux =
    (WB_ADR_IN == ADCCTL_OFS_RES_LO) ? res_lo :
    (WB_ADR_IN == ADCCTL_OFS_RES_HI) ? res_hi :
    (WB_ADR_IN == ADCCTL_OFS_CTRL_A) ? ctrl_a_r :
    (WB_ADR_IN == ADCCTL_OFS_CTRL_B) ? ctrl_b_r :
    (WB_ADR_IN == ADCCTL_OFS_MUX) ? mux_r :
    (WB_ADR_IN == ADCCTL_OFS_PIN_DIS) ? pin_dis_r : 8'h00;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
      PORT_PIN_OUT <= 8'h00;
      PIN_BUFFER_OFF_OUT <= 8'h00;
      COMPARATOR_MUX_BORROW_OUT <= 1'b0;
      CHANNEL_SELECT_OUT <= 4'h0;
      REFERENCE_SELECT_OUT <= 2'h0;
      CONVERTER_ON_OUT <= 1'b0;
      SAMPLE_OUT <= 1'b0;
      COMPLETE_IRQ_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= access;
      WB_DAT_OUT <= rd ? {24'h000000, rd_mux} : 32'h0000_0000;
      PORT_PIN_OUT <= PORT_PIN_IN & ~pin_dis_r;
      PIN_BUFFER_OFF_OUT <= pin_dis_r;
      COMPARATOR_MUX_BORROW_OUT <= ctrl_b_r[ADCCTL_BIT_BORROW] && !en;
      CHANNEL_SELECT_OUT <= mux_r[3:0];
      REFERENCE_SELECT_OUT <= mux_r[7:6];
      CONVERTER_ON_OUT <= en;
      SAMPLE_OUT <= (state_nxt == ADCCTL_CONV);
      COMPLETE_IRQ_OUT <= ctrl_a_nxt[ADCCTL_BIT_DONE] && ctrl_a_nxt[ADCCTL_BIT_IRQEN] && GLOBAL_IRQ_EN_IN;
    end
  end

  // ============================================================
  // checks
  property p_irq;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    COMPLETE_IRQ_OUT |-> $past(ctrl_a_nxt[ADCCTL_BIT_IRQEN]) && $past(GLOBAL_IRQ_EN_IN);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enables");
  property p_lock;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    locked_r && !rd_hi |=> $stable(result_r);
  endproperty
  a_lock: assert property (p_lock) else $error("result changed while locked");
  property p_right;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !align_left |-> res_hi[7:2] == 6'h00 && {res_hi[1:0], res_lo} == result_r;
  endproperty
  a_right: assert property (p_right) else $error("right align wrong");
  property p_left;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    align_left |-> res_lo[5:0] == 6'h00 && {res_hi, res_lo[7:6]} == result_r;
  endproperty
  a_left: assert property (p_left) else $error("left align wrong");
  property p_borrow;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    COMPARATOR_MUX_BORROW_OUT |-> $past(!en);
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow while enabled");
  property p_noauto;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !auto_en |-> !trig_edge;
  endproperty
  a_noauto: assert property (p_noauto) else $error("trigger without auto");
  property p_abort;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !en |=> state_r != ADCCTL_CONV;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion kept after disable");
  property p_pin;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    ##1 (PORT_PIN_OUT & $past(pin_dis_r)) == 8'h00;
  endproperty
  a_pin: assert property (p_pin) else $error("disabled pin reads one");
  property p_done;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    set_done |=> done_flag;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");
endmodule : adcctl_top

// File: rtl/adcctl_pkg.sv
// package of constants for the converter control block
// assumes a wishbone classic slave with 8-bit registers in the low byte lane
package adcctl_pkg;
  localparam logic [7:0] ADCCTL_OFS_RES_LO = 8'h78;
  localparam logic [7:0] ADCCTL_OFS_RES_HI = 8'h79;
  localparam logic [7:0] ADCCTL_OFS_CTRL_A = 8'h7a;
  localparam logic [7:0] ADCCTL_OFS_CTRL_B = 8'h7b;
  localparam logic [7:0] ADCCTL_OFS_MUX = 8'h7c;
  localparam logic [7:0] ADCCTL_OFS_PIN_DIS = 8'h7e;
  localparam logic [7:0] ADCCTL_RESET_VAL = 8'h00;
  localparam int ADCCTL_BIT_EN = 7;
  localparam int ADCCTL_BIT_START = 6;
  localparam int ADCCTL_BIT_AUTO = 5;
  localparam int ADCCTL_BIT_DONE = 4;
  localparam int ADCCTL_BIT_IRQEN = 3;
  localparam int ADCCTL_BIT_ALIGN = 5;
  localparam int ADCCTL_BIT_BORROW = 6;
  localparam int ADCCTL_RES_W = 10;
  localparam logic [4:0] ADCCTL_CONV_CYCLES = 5'h0d;
  localparam logic [4:0] ADCCTL_FIRST_CYCLES = 5'h19;
  localparam logic [2:0] ADCCTL_TRIG_FREE = 3'h0;
  localparam logic [2:0] ADCCTL_TRIG_COMP = 3'h1;
  localparam logic [2:0] ADCCTL_TRIG_EXT0 = 3'h2;
  localparam logic [2:0] ADCCTL_TRIG_T0CA = 3'h3;
  localparam logic [2:0] ADCCTL_TRIG_T0OV = 3'h4;
  localparam logic [2:0] ADCCTL_TRIG_T1CB = 3'h5;
  localparam logic [2:0] ADCCTL_TRIG_T1OV = 3'h6;
  localparam logic [2:0] ADCCTL_TRIG_T1CAP = 3'h7;
  typedef enum logic [2:0] {
    ADCCTL_IDLE = 3'b001,
    ADCCTL_CONV = 3'b010,
    ADCCTL_DONE = 3'b100
  } adcctl_state_t;
endpackage : adcctl_pkg

// File: rtl/adcctl_prescaler.sv
// converter clock prescaler: one-cycle tick at clk divided by 2..128
// assumes a single system clock and synchronous enable
`timescale 1ns/1ps
module adcctl_prescaler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  import adcctl_pkg::*;
  logic [6:0] cnt_r;
  logic [6:0] limit;
  // codes 0 and 1 both divide by two
  assign limit = (sel_in <= 3'h1) ? 7'h01 : 7'((8'h01 << sel_in) - 8'h01);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 7'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt_r >= limit);
      cnt_r <= (cnt_r >= limit) ? 7'h00 : cnt_r + 7'h01;
    end
  end
endmodule : adcctl_prescaler

// File: tb/tb_top.sv
// self-checking bench for the converter control block
// assumes adcctl_top with a classic wishbone slave and one 40 MHz clock
`timescale 1ns/1ps
module tb_top;
  import adcctl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0, vec = 1'b0;
  logic [7:0] adr = 8'h00, pin = 8'h00, pout, boff;
  logic [31:0] dwr = 32'h0, drd;
  logic [6:0] flg = 7'h00;
  logic [9:0] res_in = 10'h000;
  logic ack, borrow, con, smp, irq;
  logic [3:0] chsel;
  logic [1:0] rsel;
  int err_count = 0, n_tests = 0, cycles = 0;

  adcctl_top dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(dwr), .WB_DAT_OUT(drd), .WB_ACK_OUT(ack),
    .GLOBAL_IRQ_EN_IN(gie), .VECTOR_TAKEN_IN(vec), .TRIG_FLAGS_IN(flg), .CONV_RESULT_IN(res_in),
    .PORT_PIN_IN(pin), .PORT_PIN_OUT(pout), .PIN_BUFFER_OFF_OUT(boff), .COMPARATOR_MUX_BORROW_OUT(borrow),
    .CHANNEL_SELECT_OUT(chsel), .REFERENCE_SELECT_OUT(rsel), .CONVERTER_ON_OUT(con), .SAMPLE_OUT(smp),
    .COMPLETE_IRQ_OUT(irq));

  // ==========================================
  // clock, watchdog, report
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ==========================================
  // bus, stimulus and model helpers
  // ack and read data are taken at the edge that samples ack high, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dwr <= {24'h0, d};
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) err_count++;
    q = drd[7:0];
    cyc <= 1'b0; stb <= 1'b0;
    @(negedge clk);
  endtask : wb
  task automatic drv(input logic [6:0] f, input logic v);
    @(posedge clk);
    flg <= f; vec <= v;
  endtask : drv
  task automatic conv(output int n);
    int k;
    k = 0; n = 0;
    while (smp !== 1'b1 && k < 20) begin @(negedge clk); k++; end
    while (smp === 1'b1 && n < 5000) begin @(negedge clk); n++; end
    @(negedge clk);
  endtask : conv
  task automatic quiet(output logic [7:0] s);
    s = 8'h00;
    repeat (12) begin @(negedge clk); s[0] = s[0] | smp; end
  endtask : quiet
  function automatic logic [7:0] pres(input logic [9:0] r, input logic al, input logic hi);
    if (al) return hi ? r[9:2] : {r[1:0], 6'h00};
    return hi ? {6'h00, r[9:8]} : r[7:0];
  endfunction : pres

  // ==========================================
  // main sequence
  initial begin
    logic [7:0] q, d, s;
    logic [9:0] shown;
    logic [7:0] ra [7] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h70};
    int n, dv, o;
    void'($urandom(32'h0447e1b7));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, 8'h70, 8'hff, q);
    foreach (ra[i]) begin wb(1'b0, ra[i], 8'h00, q); chk(q, 8'h00); end
    d = $urandom;
    pin <= $urandom;
    wb(1'b1, 8'h7e, d, q); wb(1'b0, 8'h7e, 8'h00, q); chk(q, d);
    chk(boff, d);
    chk(pout, pin & ~d);
    wb(1'b1, 8'h7b, 8'h40, q); wb(1'b0, 8'h7b, 8'h00, q); chk(q, 8'h40);
    chk({7'h0, borrow}, 8'h01);
    wb(1'b1, 8'h7c, 8'hc9, q); chk({2'h0, rsel, chsel}, 8'h39);
    // every divider code; the first conversion after enable runs 25 ticks
    for (int c = 0; c < 8; c++) begin
      dv = (c < 2) ? 2 : (1 << c);
      gie <= c[1]; res_in <= $urandom;
      wb(1'b1, 8'h7c, {2'h0, c[0], 5'h00}, q);
      wb(1'b1, 8'h7a, 8'h00, q);
      wb(1'b1, 8'h7a, 8'hc8 | c[7:0], q);
      chk({7'h0, borrow}, 8'h00);
      conv(n);
      chk({7'h0, (n >= 24 * dv && n <= 26 * dv + 4)}, 8'h01);
      chk({7'h0, irq}, {7'h0, gie});
      wb(1'b0, 8'h7a, 8'h00, q); chk(q & 8'h10, 8'h10);
      wb(1'b0, 8'h78, 8'h00, q); chk(q, pres(res_in, c[0], 1'b0));
      wb(1'b0, 8'h79, 8'h00, q); chk(q, pres(res_in, c[0], 1'b1));
      wb(1'b1, 8'h7a, 8'h98 | c[7:0], q); wb(1'b0, 8'h7a, 8'h00, q); chk(q & 8'h10, 8'h00);
    end
    // a low read holds the pair until the high read
    wb(1'b1, 8'h7c, 8'h00, q);
    shown = res_in;
    wb(1'b0, 8'h78, 8'h00, q);
    res_in <= ~shown;
    wb(1'b1, 8'h7a, 8'hc0, q); conv(n);
    wb(1'b0, 8'h7a, 8'h00, q); chk(q & 8'h10, 8'h00);
    wb(1'b0, 8'h79, 8'h00, q); chk(q, pres(shown, 1'b0, 1'b1));
    wb(1'b0, 8'h78, 8'h00, q); chk(q, pres(shown, 1'b0, 1'b0));
    wb(1'b0, 8'h79, 8'h00, q);
    wb(1'b1, 8'h7c, 8'h20, q);
    for (int i = 0; i < 2; i++) begin
      res_in <= $urandom;
      wb(1'b1, 8'h7a, 8'hd0, q); conv(n);
      wb(1'b0, 8'h79, 8'h00, q); chk(q, pres(res_in, 1'b1, 1'b1));
    end
    drv(7'h00, 1'b1); drv(7'h00, 1'b0);
    wb(1'b0, 8'h7a, 8'h00, q); chk(q & 8'h10, 8'h00);
    wb(1'b1, 8'h7a, 8'hc0, q); wb(1'b1, 8'h7a, 8'h00, q);
    chk({6'h0, con, smp}, 8'h00);
    chk({7'h0, borrow}, 8'h01);
    wb(1'b0, 8'h7a, 8'h00, q); chk(q & 8'h50, 8'h00);
    // trigger sources: ignored without auto mode, then each code in turn
    wb(1'b1, 8'h7b, 8'h01, q); wb(1'b1, 8'h7a, 8'h80, q);
    drv(7'h01, 1'b0); quiet(s); chk(s, 8'h00);
    drv(7'h00, 1'b0);
    wb(1'b1, 8'h7a, 8'ha0, q);
    for (int c = 1; c < 8; c++) begin
      o = (c % 7) + 1;
      wb(1'b1, 8'h7b, o[7:0], q);
      drv(7'h01 << (c - 1), 1'b0); quiet(s); chk(s, 8'h00);
      wb(1'b1, 8'h7b, c[7:0], q); conv(n); chk({7'h0, n > 0}, 8'h01);
      drv(7'h00, 1'b0); quiet(s); chk(s, 8'h00);
      drv(7'h01 << (c - 1), 1'b0); conv(n); chk({7'h0, n > 0}, 8'h01);
      drv(7'h00, 1'b0);
    end
    wb(1'b1, 8'h7b, 8'h00, q); quiet(s); chk(s, 8'h00);
    wb(1'b1, 8'h7a, 8'h00, q);
    finish_test();
  end
endmodule : tb_top
